//--- rtl/iqf_bus_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "iqf_defs.svh"

module iqf_bus_timer (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // request
    input wire logic req_in,
    input wire logic we_in,
    // answer
    output logic fire_out,
    output logic ack_out
);
    logic [1:0] cnt_ff;
    logic done_ff;
    logic ack_ff;
    logic [1:0] target;

    // flag register writes are stretched by two cycles over everything else
    assign target = we_in ? 2'(`IQF_RD_WAIT + `IQF_WR_EXTRA) : `IQF_RD_WAIT;
    assign fire_out = req_in && !done_ff && (cnt_ff == target);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_ff <= 2'h0;
            done_ff <= 1'b0;
        end else if (!req_in) begin
            cnt_ff <= 2'h0;
            done_ff <= 1'b0;
        end else if (fire_out) begin
            done_ff <= 1'b1;
        end else if (!done_ff) begin
            cnt_ff <= 2'(cnt_ff + 2'h1);
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= fire_out;
        end
    end

    assign ack_out = ack_ff;
endmodule
`default_nettype wire

//--- rtl/iqf_defs.svh
`ifndef IQF_DEFS_SVH
`define IQF_DEFS_SVH

// ================================================================
// register indices (byte address is four times the index)
`define IQF_IDX_B2L 20'hFFFD0
`define IQF_IDX_B2H 20'hFFFD1
`define IQF_IDX_B0L 20'hFFFE0
`define IQF_IDX_B0H 20'hFFFE1
`define IQF_IDX_B1L 20'hFFFE2
`define IQF_IDX_B1H 20'hFFFE3
`define IQF_IDX_W0 20'hFFFF0
`define IQF_IDX_W1 20'hFFFF1
`define IQF_IDX_W2 20'hFFFF2
`define IQF_IDX_BIT 20'hFFFF4
`define IQF_IDX_STAT 20'hFFFF8
`define IQF_IDX_MASK 20'hFFFF9

// ================================================================
// byte positions inside the flag array
`define IQF_BYTE_B0L 3'h0
`define IQF_BYTE_B0H 3'h1
`define IQF_BYTE_B1L 3'h2
`define IQF_BYTE_B1H 3'h3
`define IQF_BYTE_B2L 3'h4
`define IQF_BYTE_B2H 3'h5
`define IQF_BYTE_LAST 3'h5

// ================================================================
// bank 0 low byte fields
`define IQF_WATCHDOG_INTERVAL_PENDING 0
`define IQF_LOW_VOLTAGE_DETECT_PENDING 1
`define IQF_EXT_PIN0_PENDING 2
`define IQF_EXT_PIN1_PENDING 3
`define IQF_EXT_PIN2_PENDING 4
`define IQF_EXT_PIN3_PENDING 5

// ================================================================
// bit operation register fields
`define IQF_BITOP_BIT_LSB 0
`define IQF_BITOP_BYTE_LSB 3
`define IQF_BITOP_VALUE 6

// ================================================================
// status bits
`define IQF_ST_BANK0 0
`define IQF_ST_BANK1 1
`define IQF_ST_BANK2 2
`define IQF_ST_OVERRUN 3

// ================================================================
// reset values and timing
`define IQF_FLAG_RST 8'h00
`define IQF_STAT_RST 4'h0
`define IQF_MASK_RST 4'h0
`define IQF_RD_WAIT 2'h0
`define IQF_WR_EXTRA 2'h2

`endif

//--- rtl/iqf_flag_byte.sv
`timescale 1ns/1ps
`default_nettype none
`include "iqf_defs.svh"

module iqf_flag_byte (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // update terms
    input wire iqf_pkg::iqf_byte_type req_in,
    input wire iqf_pkg::iqf_byte_type ack_clr_in,
    input wire iqf_pkg::iqf_byte_type wr_mask_in,
    input wire iqf_pkg::iqf_byte_type wr_data_in,
    // state
    output iqf_pkg::iqf_byte_type flags_out
);
    import iqf_pkg::*;

    iqf_byte_type flags_ff;
    iqf_byte_type nxt_flags;

    // ================================================================
    // software write, then acknowledge clear, then source set
    always_comb begin
        nxt_flags = (flags_ff & ~wr_mask_in) | (wr_data_in & wr_mask_in);
        nxt_flags = nxt_flags & ~ack_clr_in;
        // a request landing on a clear still sets the flag
        nxt_flags = nxt_flags | req_in;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags_ff <= `IQF_FLAG_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_out = flags_ff;
endmodule
`default_nettype wire

//--- rtl/iqf_pkg.sv
package iqf_pkg;
    typedef logic [7:0] iqf_byte_type;
    typedef logic [47:0] iqf_flags_type;
    typedef logic [3:0] iqf_status_type;
    typedef enum logic {IQF_DIR_READ, IQF_DIR_WRITE} iqf_dir_type;
endpackage

//--- rtl/iqf_top.sv
// Function
// - a source request or a software write of one sets a pending flag
// - software write of zero, acknowledge or reset clears a pending flag
// - acknowledge clears the matching flag before the service routine starts
// - each flag byte accepts single bit and whole byte writes
// - low and high flag bytes pair into one halfword register
// - reset leaves every flag register at zero
// - any flag register write takes two extra clocks
// - bank zero low byte holds watchdog, low voltage and pin 0..3 flags
`timescale 1ns/1ps
`default_nettype none
`include "iqf_defs.svh"

module iqf_top (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [21:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // peripheral requests, one bit per flag
    input wire iqf_pkg::iqf_flags_type src_req_in,
    // cpu acknowledge
    input wire logic cpu_ack_valid_in,
    input wire logic [5:0] cpu_ack_index_in,
    // state
    output iqf_pkg::iqf_flags_type pending_out,
    output logic irq_out
);
    import iqf_pkg::*;

    // ================================================================
    // bus decode
    logic req;
    logic fire;
    logic commit;
    logic [19:0] idx;
    logic [31:0] rd_word;
    logic [31:0] dat_ff;
    iqf_dir_type dir;
    logic flag_hit;
    logic slow_wr;

    assign req = wb_cyc_in && wb_stb_in;
    assign idx = wb_adr_in[21:2];
    assign dir = wb_we_in ? IQF_DIR_WRITE : IQF_DIR_READ;
    // the write lands on the edge where the master sees ack
    assign commit = wb_ack_out && req && (dir == IQF_DIR_WRITE);

    // only flag registers pay the extra write clocks; status, mask and holes answer
    // as fast as a read, so software polling them is not slowed down
    always_comb begin
        unique case (idx)
            `IQF_IDX_B0L, `IQF_IDX_B0H, `IQF_IDX_B1L, `IQF_IDX_B1H: begin
                flag_hit = 1'b1;
            end
            `IQF_IDX_B2L, `IQF_IDX_B2H: begin
                flag_hit = 1'b1;
            end
            `IQF_IDX_W0, `IQF_IDX_W1, `IQF_IDX_W2, `IQF_IDX_BIT: begin
                flag_hit = 1'b1;
            end
            default: begin
                flag_hit = 1'b0;
            end
        endcase
    end

    assign slow_wr = (dir == IQF_DIR_WRITE) && flag_hit;

    iqf_bus_timer u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .req_in(req),
        .we_in(slow_wr),
        .fire_out(fire),
        .ack_out(wb_ack_out)
    );

    // ================================================================
    // flag bytes
    iqf_byte_type flag_q [6];
    iqf_byte_type wr_mask [6];
    iqf_byte_type wr_data [6];
    iqf_byte_type ack_clr [6];
    iqf_flags_type flags;

    // one flop byte per flag register; a bank word is two neighbouring bytes
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_byte
            iqf_flag_byte u_byte (
                .sys_clk_in(sys_clk_in),
                .reset_in(reset_in),
                .req_in(src_req_in[8*g +: 8]),
                .ack_clr_in(ack_clr[g]),
                .wr_mask_in(wr_mask[g]),
                .wr_data_in(wr_data[g]),
                .flags_out(flag_q[g])
            );
            assign flags[8*g +: 8] = flag_q[g];
        end
    endgenerate

    assign pending_out = flags;

    // ================================================================
    // acknowledge decode: index is byte in [5:3], bit in [2:0]
    // an index past the last flag byte names no flag and is dropped
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            ack_clr[i] = 8'h00;
        end
        if (cpu_ack_valid_in && (cpu_ack_index_in[5:3] <= `IQF_BYTE_LAST)) begin
            ack_clr[cpu_ack_index_in[5:3]] = 8'(8'h01 << cpu_ack_index_in[2:0]);
        end
    end

    // ================================================================
    // write decode
    logic [2:0] bit_pos;
    logic [2:0] bit_byte;
    logic bit_val;

    assign bit_pos = wb_dat_in[`IQF_BITOP_BIT_LSB +: 3];
    assign bit_byte = wb_dat_in[`IQF_BITOP_BYTE_LSB +: 3];
    assign bit_val = wb_dat_in[`IQF_BITOP_VALUE];

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            wr_mask[i] = 8'h00;
            wr_data[i] = 8'h00;
        end
        if (commit) begin
            unique case (idx)
                `IQF_IDX_B0L: begin
                    wr_mask[`IQF_BYTE_B0L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B0L] = wb_dat_in[7:0];
                end
                `IQF_IDX_B0H: begin
                    wr_mask[`IQF_BYTE_B0H] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B0H] = wb_dat_in[7:0];
                end
                `IQF_IDX_B1L: begin
                    wr_mask[`IQF_BYTE_B1L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B1L] = wb_dat_in[7:0];
                end
                `IQF_IDX_B1H: begin
                    wr_mask[`IQF_BYTE_B1H] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B1H] = wb_dat_in[7:0];
                end
                `IQF_IDX_B2L: begin
                    wr_mask[`IQF_BYTE_B2L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B2L] = wb_dat_in[7:0];
                end
                `IQF_IDX_B2H: begin
                    wr_mask[`IQF_BYTE_B2H] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B2H] = wb_dat_in[7:0];
                end
                `IQF_IDX_W0: begin
                    // low byte in the lower half of the halfword
                    wr_mask[`IQF_BYTE_B0L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B0L] = wb_dat_in[7:0];
                    wr_mask[`IQF_BYTE_B0H] = {8{wb_sel_in[1]}};
                    wr_data[`IQF_BYTE_B0H] = wb_dat_in[15:8];
                end
                `IQF_IDX_W1: begin
                    wr_mask[`IQF_BYTE_B1L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B1L] = wb_dat_in[7:0];
                    wr_mask[`IQF_BYTE_B1H] = {8{wb_sel_in[1]}};
                    wr_data[`IQF_BYTE_B1H] = wb_dat_in[15:8];
                end
                `IQF_IDX_W2: begin
                    wr_mask[`IQF_BYTE_B2L] = {8{wb_sel_in[0]}};
                    wr_data[`IQF_BYTE_B2L] = wb_dat_in[7:0];
                    wr_mask[`IQF_BYTE_B2H] = {8{wb_sel_in[1]}};
                    wr_data[`IQF_BYTE_B2H] = wb_dat_in[15:8];
                end
                `IQF_IDX_BIT: begin
                    // single bit write touches only the addressed flag
                    if (wb_sel_in[0] && (bit_byte <= `IQF_BYTE_LAST)) begin
                        wr_mask[bit_byte] = 8'(8'h01 << bit_pos);
                        wr_data[bit_byte] = bit_val ? 8'(8'h01 << bit_pos) : 8'h00;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ================================================================
    // interrupt status and mask
    iqf_status_type status_ff;
    iqf_status_type mask_ff;
    iqf_status_type events;
    iqf_status_type stat_clr;
    iqf_flags_type overrun;
    logic stat_wr;
    logic mask_wr;

    // a request hitting an already pending flag would be merged, so flag it
    assign overrun = src_req_in & flags;
    assign events[`IQF_ST_BANK0] = |src_req_in[15:0];
    assign events[`IQF_ST_BANK1] = |src_req_in[31:16];
    assign events[`IQF_ST_BANK2] = |src_req_in[47:32];
    assign events[`IQF_ST_OVERRUN] = |overrun;

    assign stat_wr = commit && (idx == `IQF_IDX_STAT) && wb_sel_in[0];
    assign mask_wr = commit && (idx == `IQF_IDX_MASK) && wb_sel_in[0];

    always_comb begin
        stat_clr = 4'h0;
        if (stat_wr) begin
            stat_clr = wb_dat_in[3:0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            status_ff <= `IQF_STAT_RST;
        end else begin
            // set wins over write-one-to-clear
            status_ff <= (status_ff & ~stat_clr) | events;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mask_ff <= `IQF_MASK_RST;
        end else if (mask_wr) begin
            mask_ff <= wb_dat_in[3:0];
        end
    end

    // level output: stays high until software clears the status bit or masks it
    assign irq_out = |(status_ff & mask_ff);

    // ================================================================
    // read path
    // holes read as zero but are still acknowledged
    always_comb begin
        rd_word = 32'h00000000;
        unique case (idx)
            `IQF_IDX_B0L: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B0L];
            end
            `IQF_IDX_B0H: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B0H];
            end
            `IQF_IDX_B1L: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B1L];
            end
            `IQF_IDX_B1H: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B1H];
            end
            `IQF_IDX_B2L: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B2L];
            end
            `IQF_IDX_B2H: begin
                rd_word[7:0] = flag_q[`IQF_BYTE_B2H];
            end
            `IQF_IDX_W0: begin
                rd_word[15:0] = flags[15:0];
            end
            `IQF_IDX_W1: begin
                rd_word[15:0] = flags[31:16];
            end
            `IQF_IDX_W2: begin
                rd_word[15:0] = flags[47:32];
            end
            `IQF_IDX_STAT: begin
                rd_word[3:0] = status_ff;
            end
            `IQF_IDX_MASK: begin
                rd_word[3:0] = mask_ff;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // read data is captured on the same edge that raises ack and stands only while ack does
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            dat_ff <= 32'h00000000;
        end else if (fire && (dir == IQF_DIR_READ)) begin
            dat_ff <= rd_word;
        end else begin
            dat_ff <= 32'h00000000;
        end
    end

    assign wb_dat_out = dat_ff;
endmodule
`default_nettype wire

//--- tb/interrupt_request_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "iqf_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end

module interrupt_request_flags_tb;
    import iqf_pkg::*;
    typedef struct {logic [19:0] i; logic [3:0] s; logic [31:0] w; logic [31:0] r;} iqf_row_type;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [21:0] wb_adr_in = 22'h0;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    iqf_flags_type src_req_in;
    logic cpu_ack_valid_in;
    logic [5:0] cpu_ack_index_in;
    iqf_flags_type pending_out;
    logic irq_out;
    logic [31:0] rd;
    int fails = 0;
    int compares = 0;
    iqf_row_type rows [13] = '{
        '{`IQF_IDX_B0L, 4'h1, 32'hFF, 32'hFF}, '{`IQF_IDX_B0L, 4'h1, 32'h0, 32'h0},
        '{`IQF_IDX_B0H, 4'h1, 32'hA5, 32'hA5}, '{`IQF_IDX_B1L, 4'h1, 32'h5A, 32'h5A},
        '{`IQF_IDX_B1H, 4'h1, 32'hC3, 32'hC3}, '{`IQF_IDX_B2L, 4'h1, 32'h81, 32'h81},
        '{`IQF_IDX_B2H, 4'h1, 32'h7E, 32'h7E}, '{`IQF_IDX_W0, 4'h3, 32'h1234, 32'h1234},
        '{`IQF_IDX_W1, 4'h3, 32'hFFFF00FF, 32'hFF}, '{`IQF_IDX_W2, 4'h3, 32'hBEEF, 32'hBEEF},
        '{`IQF_IDX_B0L, 4'h0, 32'hFF, 32'h34}, '{20'h00010, 4'h1, 32'hFF, 32'h0},
        '{`IQF_IDX_MASK, 4'h1, 32'hFA, 32'hA}};

    always #2 sys_clk_in = ~sys_clk_in;

    iqf_top uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .src_req_in(src_req_in), .cpu_ack_valid_in(cpu_ack_valid_in),
        .cpu_ack_index_in(cpu_ack_index_in), .pending_out(pending_out), .irq_out(irq_out));
    iqf_src_model mdl (.sys_clk_in(sys_clk_in), .src_req_out(src_req_in),
        .ack_valid_out(cpu_ack_valid_in), .ack_index_out(cpu_ack_index_in));

    // ================================================================
    // bus and closing
    task automatic wb(input logic we, input logic [19:0] i, input logic [3:0] s,
                      input logic [31:0] w, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= {i, 2'h0};
        wb_sel_in <= s;
        wb_dat_in <= w;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        r = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
        wb_dat_in <= ~w;
        if (n >= 50) begin
            fails++;
            $display("BAD wb_ack_out exp 1 got 0");
        end
        @(negedge sys_clk_in);
    endtask

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        results();
    end

    initial begin
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        @(negedge sys_clk_in);
        `CHK("reset flags", 48'h0, pending_out)
        foreach (rows[k]) begin
            wb(1'b1, rows[k].i, rows[k].s, rows[k].w, rd);
            wb(1'b0, rows[k].i, 4'hF, 32'h0, rd);
            `CHK("row read", rows[k].r, rd)
        end
        wb(1'b1, `IQF_IDX_BIT, 4'h1, 32'h43, rd);
        `CHK("bit set", 8'h3C, pending_out[7:0])
        wb(1'b1, `IQF_IDX_BIT, 4'h1, 32'h02, rd);
        `CHK("bit clear", 8'h38, pending_out[7:0])
        wb(1'b1, `IQF_IDX_BIT, 4'h1, 32'h7B, rd);
        `CHK("bad byte", 48'hBEEF00FF1238, pending_out)
        wb(1'b1, `IQF_IDX_W0, 4'h3, 32'h0, rd);
        mdl.pulse(`IQF_EXT_PIN0_PENDING, -1);
        `CHK("pin0", 8'h04, pending_out[7:0])
        `CHK("irq masked", 1'b0, irq_out)
        wb(1'b1, `IQF_IDX_MASK, 4'h1, 32'h1, rd);
        `CHK("irq on", 1'b1, irq_out)
        mdl.pulse(-1, `IQF_EXT_PIN0_PENDING);
        `CHK("ack clear", 8'h00, pending_out[7:0])
        wb(1'b1, `IQF_IDX_STAT, 4'h1, 32'h1, rd);
        `CHK("irq off", 1'b0, irq_out)
        mdl.pulse(`IQF_WATCHDOG_INTERVAL_PENDING, `IQF_WATCHDOG_INTERVAL_PENDING);
        `CHK("req wins", 8'h01, pending_out[7:0])
        // a request on a pending flag plus requests in banks 1 and 2 fill every status bit
        mdl.pulse(`IQF_WATCHDOG_INTERVAL_PENDING, -1);
        mdl.pulse(20, -1);
        mdl.pulse(40, -1);
        `CHK("req banks", 48'hBFEF00FF0001, pending_out)
        wb(1'b0, `IQF_IDX_STAT, 4'h1, 32'h0, rd);
        `CHK("status all", 32'hF, rd)
        wb(1'b1, `IQF_IDX_STAT, 4'h1, 32'h6, rd);
        wb(1'b0, `IQF_IDX_STAT, 4'h1, 32'h0, rd);
        `CHK("status w1c", 32'h9, rd)
        `CHK("irq held", 1'b1, irq_out)
        // a second reset in mid-run drops every flag, the status and the mask
        @(posedge sys_clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        `CHK("reset mid", 48'h0, pending_out)
        `CHK("reset irq", 1'b0, irq_out)
        reset_in <= 1'b0;
        wb(1'b0, `IQF_IDX_W2, 4'h3, 32'h0, rd);
        `CHK("read after reset", 32'h0, rd)
        results();
    end
endmodule
`default_nettype wire

//--- tb/iqf_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module iqf_src_model (
    // clock
    input wire logic sys_clk_in,
    // events
    output iqf_pkg::iqf_flags_type src_req_out,
    output logic ack_valid_out,
    output logic [5:0] ack_index_out
);
    import iqf_pkg::*;
    initial begin
        src_req_out = 48'h0;
        ack_valid_out = 1'b0;
        ack_index_out = 6'h3F;
    end
    // one-cycle pulses only: a held line would keep setting the flag
    task automatic pulse(input int r, input int a);
        @(posedge sys_clk_in);
        if (r >= 0) src_req_out[r] <= 1'b1;
        if (a >= 0) begin
            ack_valid_out <= 1'b1;
            ack_index_out <= 6'(a);
        end
        @(posedge sys_clk_in);
        src_req_out <= 48'h0;
        ack_valid_out <= 1'b0;
        ack_index_out <= ~ack_index_out;
        @(negedge sys_clk_in);
    endtask
endmodule
`default_nettype wire

//--- tb/iqf_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "iqf_defs.svh"

module iqf_top_properties (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [21:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // events and state
    input wire iqf_pkg::iqf_flags_type src_req_in,
    input wire logic cpu_ack_valid_in,
    input wire logic [5:0] cpu_ack_index_in,
    input wire iqf_pkg::iqf_flags_type pending_out,
    input wire logic irq_out
);
    import iqf_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // flag registers are the ones whose writes take the two extra clocks
    logic flag_adr;
    assign flag_adr = wb_adr_in[21:2] inside {`IQF_IDX_B2L, `IQF_IDX_B2H, `IQF_IDX_B0L,
        `IQF_IDX_B0H, `IQF_IDX_B1L, `IQF_IDX_B1H, `IQF_IDX_W0, `IQF_IDX_W1, `IQF_IDX_W2,
        `IQF_IDX_BIT};
    // ================================================================
    // flags
    property p_req_sets;
        |src_req_in |=> (pending_out & $past(src_req_in)) == $past(src_req_in);
    endproperty
    a_req_sets: assert property (p_req_sets) else $error("flag not set");
    property p_ack_clr;
        cpu_ack_valid_in && cpu_ack_index_in < 6'h30 && !src_req_in[cpu_ack_index_in]
            |=> !pending_out[$past(cpu_ack_index_in)];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack left flag");
    property p_hold;
        !(|src_req_in) && !cpu_ack_valid_in && !(wb_ack_out && wb_we_in) |=> $stable(pending_out);
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved");
    property p_rst;
        $fell(reset_in) |-> pending_out == 48'h0 && !irq_out && !wb_ack_out;
    endproperty
    a_rst: assert property (p_rst) else $error("not clear after reset");
    // ================================================================
    // bus
    property p_rd_lat;
        $rose(wb_cyc_in && wb_stb_in) && !wb_we_in |-> !wb_ack_out ##1 wb_ack_out;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read ack time");
    property p_wr_lat;
        $rose(wb_cyc_in && wb_stb_in) && wb_we_in && flag_adr
            |-> !wb_ack_out [*3] ##1 wb_ack_out;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write ack time");
    property p_plain_wr;
        $rose(wb_cyc_in && wb_stb_in) && wb_we_in && !flag_adr |-> !wb_ack_out ##1 wb_ack_out;
    endproperty
    a_plain_wr: assert property (p_plain_wr) else $error("plain write ack time");
    property p_ack_once;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    // all-zero inputs at the landing edge keep the byte free of other update terms
    property p_byte_wr;
        wb_ack_out && wb_we_in && wb_adr_in[21:2] == `IQF_IDX_B0L && wb_sel_in[0]
            && src_req_in[7:0] == 8'h00 && !cpu_ack_valid_in
            |=> pending_out[7:0] == $past(wb_dat_in[7:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("byte write lost");
    property p_word_wr;
        wb_ack_out && wb_we_in && wb_adr_in[21:2] == `IQF_IDX_W0 && wb_sel_in[1:0] == 2'h3
            && src_req_in[15:0] == 16'h0000 && !cpu_ack_valid_in
            |=> pending_out[15:0] == $past(wb_dat_in[15:0]);
    endproperty
    a_word_wr: assert property (p_word_wr) else $error("word write lost");
endmodule

bind iqf_top iqf_top_properties u_props (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .src_req_in(src_req_in), .cpu_ack_valid_in(cpu_ack_valid_in),
    .cpu_ack_index_in(cpu_ack_index_in), .pending_out(pending_out), .irq_out(irq_out));
`default_nettype wire
